// ### design/trc_cmd_core.sv
// serial slave command interpreter of the thermometer and calendar clock
`timescale 1ns/1ps
`include "trc_cfg.svh"
module trc_cmd_core (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // device state read back
   input wire logic [7:0] i_status_flags,
   input wire logic [7:0] i_temp_msb,
   input wire logic [7:0] i_temp_lsb,
   // settings written by the master
   output logic [7:0] o_config,
   output logic [15:0] o_high_temp_threshold,
   output logic o_clock_run,
   output logic o_hour_12_mode
);

   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic sda;

   trc_pkg::trc_state_type state_q;
   trc_pkg::trc_state_type state_d;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] tx_q;
   logic [7:0] cmd_q;
   logic [1:0] idx_q;
   logic [2:0] ptr_q;
   logic oe_q;
   logic oe_d;
   logic out_q;
   logic [7:0] clk_q [0:6];
   logic [7:0] config_q;
   logic [15:0] th_q;
   logic run_q;
   logic hour12_q;

   function automatic logic [2:0] ptr_next(input logic [2:0] p);
      ptr_next = (p == `TRC_PTR_YEAR) ? `TRC_PTR_SEC : p + 3'h1;
   endfunction

   function automatic logic [2:0] ptr_clip(input logic [7:0] b);
      ptr_clip = (b > {5'h00, `TRC_PTR_YEAR}) ? `TRC_PTR_SEC : b[2:0];
   endfunction

   function automatic logic [1:0] idx_next(input logic [1:0] i);
      idx_next = (i == `TRC_IDX_MAX) ? i : i + 2'h1;
   endfunction

   trc_line_sync u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_scl_rise(rise),
      .o_scl_fall(fall),
      .o_start(start),
      .o_stop(stop),
      .o_sda(sda)
   );

   wire at_ack = cnt_q == `TRC_BIT_ACK;
   wire at_end = cnt_q == `TRC_BIT_END;
   wire byte_done = fall && at_ack;
   wire ack_done = fall && at_end;
   wire addr_hit = (shift_q == `TRC_ADDR_WR) || (shift_q == `TRC_ADDR_RD);
   wire in_rx = (state_q == trc_pkg::TRC_CMD) || (state_q == trc_pkg::TRC_RX);
   wire in_tx = state_q == trc_pkg::TRC_TX;
   wire is_cfg = cmd_q == `TRC_CMD_CFG;
   wire is_clk = cmd_q == `TRC_CMD_CLK;
   wire is_th = cmd_q == `TRC_CMD_TH;
   wire is_temp = cmd_q == `TRC_CMD_TEMP;
   wire rx_data = byte_done && (state_q == trc_pkg::TRC_RX);
   wire ptr_wr = rx_data && is_clk && (idx_q == 2'h0);
   wire clk_wr = rx_data && is_clk && (idx_q != 2'h0);
   wire tx_load = ack_done && in_tx;
   wire tx_bit = fall && in_tx && (cnt_q != 4'h0) && (cnt_q < `TRC_BIT_ACK);
   wire master_nack = rise && at_ack && in_tx && sda;

   wire [7:0] cfg_byte = (idx_q == 2'h0) ? config_q : i_status_flags;
   wire [7:0] th_byte = (idx_q == 2'h0) ? th_q[15:8] : th_q[7:0];
   wire [7:0] temp_byte = (idx_q == 2'h0) ? i_temp_msb : i_temp_lsb;
   wire [7:0] tx_byte = is_cfg ? cfg_byte :
                        is_clk ? clk_q[ptr_q] :
                        is_th ? th_byte :
                        is_temp ? temp_byte : `TRC_IDLE_BYTE;

   always_comb begin
      state_d = state_q;
      if (start) begin
         state_d = trc_pkg::TRC_ADDR;
      end else if (stop) begin
         state_d = trc_pkg::TRC_IDLE;
      end else if (master_nack) begin
         state_d = trc_pkg::TRC_IGNORE;
      end else if (byte_done && (state_q == trc_pkg::TRC_ADDR)) begin
         if (!addr_hit) begin
            state_d = trc_pkg::TRC_IGNORE;
         end else if (shift_q[0]) begin
            state_d = trc_pkg::TRC_TX;
         end else begin
            state_d = trc_pkg::TRC_CMD;
         end
      end else if (byte_done && (state_q == trc_pkg::TRC_CMD)) begin
         state_d = trc_pkg::TRC_RX;
      end
   end

   always_comb begin
      oe_d = oe_q;
      if (start || stop || (state_q == trc_pkg::TRC_IGNORE)) begin
         oe_d = 1'b0;
      end else if (byte_done) begin
         oe_d = (state_q == trc_pkg::TRC_ADDR) ? addr_hit : in_rx;
      end else if (ack_done) begin
         oe_d = in_tx ? !tx_byte[7] : 1'b0;
      end else if (tx_bit) begin
         oe_d = !tx_q[7];
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= trc_pkg::TRC_IDLE;
         oe_q <= 1'b0;
         out_q <= 1'b0;
      end else begin
         state_q <= state_d;
         oe_q <= oe_d;
         out_q <= 1'b0;
      end
   end

   // counts data bits on rising clock, the ack slot as the ninth
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 4'h0;
      end else if (start || stop || ack_done) begin
         cnt_q <= 4'h0;
      end else if (rise && !at_end) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shift_q <= 8'h00;
      end else if (rise && (cnt_q < `TRC_BIT_ACK)) begin
         shift_q <= {shift_q[6:0], sda};
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_q <= 8'h00;
      end else if (tx_load) begin
         tx_q <= {tx_byte[6:0], 1'b0};
      end else if (tx_bit) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd_q <= 8'h00;
      end else if (byte_done && (state_q == trc_pkg::TRC_CMD)) begin
         cmd_q <= shift_q;
      end
   end

   // index of the data byte within the command, saturating
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         idx_q <= 2'h0;
      end else if (start || (byte_done && (state_q == trc_pkg::TRC_CMD))) begin
         idx_q <= 2'h0;
      end else if (rx_data || tx_load) begin
         idx_q <= idx_next(idx_q);
      end
   end

   // pointer survives a repeated start so a read can follow its set-up
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ptr_q <= `TRC_PTR_SEC;
      end else if (ptr_wr) begin
         ptr_q <= ptr_clip(shift_q);
      end else if (clk_wr || (tx_load && is_clk)) begin
         ptr_q <= ptr_next(ptr_q);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_q[0] <= `TRC_SEC_RESET;
         for (int i = 1; i < 7; i++) begin
            clk_q[i] <= `TRC_CLK_RESET;
         end
      end else if (clk_wr) begin
         clk_q[ptr_q] <= shift_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_q <= 1'b0;
         hour12_q <= 1'b0;
      end else if (clk_wr && (ptr_q == `TRC_PTR_SEC)) begin
         run_q <= !shift_q[`TRC_SEC_HALT_BIT];
      end else if (clk_wr && (ptr_q == `TRC_PTR_HOUR)) begin
         hour12_q <= shift_q[`TRC_HOUR_12_BIT];
      end
   end

   // later bytes of a configuration write are acked and dropped
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         config_q <= `TRC_CFG_RESET;
      end else if (rx_data && is_cfg && (idx_q == 2'h0)) begin
         config_q <= shift_q;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         th_q <= `TRC_TH_RESET;
      end else if (rx_data && is_th && (idx_q == 2'h0)) begin
         th_q[15:8] <= shift_q;
      end else if (rx_data && is_th && (idx_q == 2'h1)) begin
         th_q[7:0] <= shift_q;
      end
   end

   // open drain: the line is only ever pulled low
   assign o_sda_out = out_q;
   assign o_sda_oe = oe_q;
   assign o_config = config_q;
   assign o_high_temp_threshold = th_q;
   assign o_clock_run = run_q;
   assign o_hour_12_mode = hour12_q;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   addr_reject_a: assert property (
      byte_done && (state_q == trc_pkg::TRC_ADDR) && !addr_hit && !start && !stop
      |=> (state_q == trc_pkg::TRC_IGNORE) && !o_sda_oe)
      else $error("foreign address acknowledged");

   rx_ack_a: assert property (
      byte_done && in_rx && !start && !stop |=> o_sda_oe)
      else $error("received byte not acknowledged");

   // the acknowledge must stand until the falling clock that ends its slot
   ack_hold_a: assert property (
      o_sda_oe && in_rx && !fall && !start && !stop |=> o_sda_oe)
      else $error("acknowledge released early");

   cfg_store_a: assert property (
      rx_data && is_cfg && (idx_q == 2'h0) |=> o_config == $past(shift_q))
      else $error("configuration byte not stored");

   status_read_a: assert property (
      tx_load && is_cfg && (idx_q == 2'h1) |=> o_sda_oe == !$past(i_status_flags[7]))
      else $error("status byte not sent second");

   ptr_load_a: assert property (
      ptr_wr && (shift_q == {5'h00, `TRC_PTR_MIN}) |=> ptr_q == `TRC_PTR_MIN)
      else $error("clock pointer not loaded");

   ptr_step_a: assert property (
      (clk_wr || (tx_load && is_clk)) && !ptr_wr
      |=> ptr_q == ptr_next($past(ptr_q)))
      else $error("clock pointer did not advance");

   sec_run_a: assert property (
      clk_wr && (ptr_q == `TRC_PTR_SEC) && (shift_q == 8'h00)
      |=> o_clock_run && (clk_q[0] == 8'h00))
      else $error("seconds write did not start clock");

   th_order_a: assert property (
      rx_data && is_th && (idx_q == 2'h1)
      |=> (o_high_temp_threshold[7:0] == $past(shift_q)) && $stable(o_high_temp_threshold[15:8]))
      else $error("threshold low byte misplaced");

   restart_a: assert property (
      start |=> (state_q == trc_pkg::TRC_ADDR) && (cnt_q == 4'h0) && !o_sda_oe)
      else $error("repeated start not honoured");

   nack_quiet_a: assert property (
      (state_q == trc_pkg::TRC_IGNORE) && !start |=> !o_sda_oe)
      else $error("line driven after nack");

   cfg_write_c: cover property (rx_data && is_cfg);
   clk_read_c: cover property (tx_load && is_clk && (ptr_q == `TRC_PTR_YEAR));
   temp_read_c: cover property (tx_load && is_temp && (idx_q == 2'h1));
   nack_c: cover property (master_nack);

endmodule

// ### design/trc_line_sync.sv
// synchroniser and start, stop and edge detector for the two serial lines
`timescale 1ns/1ps
module trc_line_sync (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // raw pins
   input wire logic i_scl,
   input wire logic i_sda,
   // line events
   output logic o_scl_rise,
   output logic o_scl_fall,
   output logic o_start,
   output logic o_stop,
   output logic o_sda
);

   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;

   // idle lines are high, so reset to high to avoid a false start
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= i_scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= i_sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   assign o_scl_rise = scl_s_q && !scl_p_q;
   assign o_scl_fall = !scl_s_q && scl_p_q;
   // data moving while the clock stays high marks a frame boundary
   assign o_start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   assign o_stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   assign o_sda = sda_s_q;

endmodule

// ### pkg/trc_cfg.svh
// constants of the thermometer and calendar clock serial command interpreter
`ifndef TRC_CFG_SVH
`define TRC_CFG_SVH

// device address bytes, write and read
`define TRC_ADDR_WR 8'h9E
`define TRC_ADDR_RD 8'h9F

// command codes
`define TRC_CMD_CFG 8'hAC
`define TRC_CMD_CLK 8'hC0
`define TRC_CMD_TH 8'hA1
`define TRC_CMD_TEMP 8'hAA

// clock register pointers
`define TRC_PTR_SEC 3'h0
`define TRC_PTR_MIN 3'h1
`define TRC_PTR_HOUR 3'h2
`define TRC_PTR_YEAR 3'h6

// fields
`define TRC_SEC_HALT_BIT 7
`define TRC_HOUR_12_BIT 6

// bit counter marks: eight data bits, then the acknowledge slot
`define TRC_BIT_ACK 4'h8
`define TRC_BIT_END 4'h9

// byte index within one command
`define TRC_IDX_MAX 2'h3

// reset values, and the byte read back for commands with no read data
`define TRC_SEC_RESET 8'h80
`define TRC_CLK_RESET 8'h00
`define TRC_CFG_RESET 8'h00
`define TRC_TH_RESET 16'h0000
`define TRC_IDLE_BYTE 8'hFF

`endif

// ### pkg/trc_pkg.sv
// types of the thermometer and calendar clock serial command interpreter
package trc_pkg;

   typedef enum logic [2:0] {
      TRC_IDLE   = 3'b000,
      TRC_ADDR   = 3'b001,
      TRC_CMD    = 3'b010,
      TRC_RX     = 3'b011,
      TRC_TX     = 3'b100,
      TRC_IGNORE = 3'b101
   } trc_state_type;

endpackage

// ### test/test_trc_cmd_core.sv
// self-checking bench of the serial command interpreter against a bus master model
`timescale 1ns/1ps
`include "trc_cfg.svh"
module test_trc_cmd_core;
   // enough for about 520 bytes on the link, over four times what the test sends
   localparam int WATCH_NS = 300000;
   logic i_clk, i_nrst, scl, sda_low, sda, oe, sda_out, run, h12;
   logic [7:0] i_status_flags, i_temp_msb, i_temp_lsb, cfg, cfg_m;
   logic [15:0] th;
   logic [31:0] seed;
   logic [7:0] clk_m [7];
   int n_fail, n_tests, ptr_m;

   // open-drain line with pull-up
   assign sda = (oe | sda_low) ? 1'b0 : 1'b1;

   trc_cmd_core u_trc_cmd_core (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe(oe), .i_status_flags(i_status_flags),
      .i_temp_msb(i_temp_msb), .i_temp_lsb(i_temp_lsb), .o_config(cfg),
      .o_high_temp_threshold(th), .o_clock_run(run), .o_hour_12_mode(h12));
   trc_master_model u_trc_master_model (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(sda_low));

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic send(input logic [7:0] b);
      logic ack;
      u_trc_master_model.wr_byte(b, ack);
      check("ack", ack, 1'b1);
   endtask

   task automatic cmd(input logic [7:0] c);
      u_trc_master_model.start_cond();
      send(`TRC_ADDR_WR);
      send(c);
   endtask

   task automatic rd_open();
      u_trc_master_model.start_cond();
      send(`TRC_ADDR_RD);
   endtask

   task automatic recv(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      u_trc_master_model.rd_byte(last, d);
      check("read byte", d, exp);
   endtask

   // model pointer: seconds to year, then back to seconds
   task automatic set_ptr(input logic [7:0] p);
      send(p);
      ptr_m = (p > 8'h06) ? 0 : int'(p);
   endtask

   task automatic clk_wr(input logic [7:0] p, input logic [7:0] v[$]);
      cmd(`TRC_CMD_CLK);
      set_ptr(p);
      foreach (v[i]) begin
         send(v[i]);
         clk_m[ptr_m] = v[i];
         ptr_m = (ptr_m == 6) ? 0 : ptr_m + 1;
      end
      check("clock run", run, !clk_m[0][7]);
      check("hour mode", h12, clk_m[2][6]);
   endtask

   task automatic clk_rd(input logic [7:0] p, input int n);
      cmd(`TRC_CMD_CLK);
      set_ptr(p);
      rd_open();
      for (int i = 0; i < n; i++) begin
         recv(i == n - 1, clk_m[ptr_m]);
         ptr_m = (ptr_m == 6) ? 0 : ptr_m + 1;
      end
   endtask

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      #(WATCH_NS);
      n_fail++;
      finish_test();
   end

   initial begin
      logic [7:0] d, a;
      logic ack;
      seed = 32'h28;
      n_fail = 0;
      n_tests = 0;
      i_nrst = 1'b0;
      i_status_flags = 8'h00;
      i_temp_msb = 8'h00;
      i_temp_lsb = 8'h00;
      cfg_m = 8'h00;
      clk_m = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (20) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (4) @(negedge i_clk);
      check("reset config", cfg, 8'h00);
      check("reset threshold", th, 16'h0000);
      check("reset run", run, 1'b0);
      check("reset line", oe, 1'b0);
      check("line value", sda_out, 1'b0);
      // setup chained by repeated starts; extra bytes must be dropped
      d = rnd();
      cmd(`TRC_CMD_CFG);
      send(d);
      send(~d);
      cfg_m = d;
      check("config", cfg, cfg_m);
      clk_wr(8'h00, '{8'h00, 8'h30, 8'h51, 8'h05, 8'h01, 8'h01, 8'h98});
      cmd(`TRC_CMD_TH);
      send(8'h32);
      send(8'h00);
      send(rnd());
      check("threshold", th, 16'h3200);
      u_trc_master_model.stop_cond();
      // read from minutes, through year and wrap
      clk_rd(8'h01, 7);
      u_trc_master_model.stop_cond();
      clk_wr(8'h00, '{8'h80, 8'h45, 8'h12});
      clk_rd(8'h07, 3);
      for (int k = 0; k < 3; k++) begin
         clk_wr(rnd() % 7, '{rnd(), rnd(), rnd()});
         clk_rd(rnd() % 7, 4);
      end
      u_trc_master_model.stop_cond();
      // temperature, then clocks after the nack must be ignored
      i_temp_msb = rnd();
      i_temp_lsb = rnd();
      cmd(`TRC_CMD_TEMP);
      rd_open();
      recv(1'b0, i_temp_msb);
      recv(1'b1, i_temp_lsb);
      u_trc_master_model.wr_byte(8'h00, ack);
      check("after nack", ack, 1'b0);
      u_trc_master_model.stop_cond();
      i_status_flags = rnd();
      cmd(`TRC_CMD_CFG);
      rd_open();
      recv(1'b0, cfg_m);
      recv(1'b1, i_status_flags);
      // threshold read back, chained by a repeated start
      cmd(`TRC_CMD_TH);
      rd_open();
      recv(1'b0, 8'h32);
      recv(1'b1, 8'h00);
      u_trc_master_model.stop_cond();
      // command with no meaning here reads back idle bytes
      cmd(8'h22);
      send(rnd());
      rd_open();
      recv(1'b1, `TRC_IDLE_BYTE);
      u_trc_master_model.stop_cond();
      for (int k = 0; k < 4; k++) begin
         a = rnd();
         if (a[7:1] == 7'h4F) a = 8'h00;
         u_trc_master_model.start_cond();
         u_trc_master_model.wr_byte(a, ack);
         check("foreign address", ack, 1'b0);
         u_trc_master_model.wr_byte(`TRC_CMD_CFG, ack);
         check("foreign byte", ack, 1'b0);
         u_trc_master_model.stop_cond();
         check("idle line", oe, 1'b0);
      end
      finish_test();
   end
endmodule

// ### test/trc_master_model.sv
// two-wire bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module trc_master_model (
   // clock
   input wire logic i_clk,
   // resolved data line
   input wire logic i_sda,
   // master pins
   output logic o_scl,
   output logic o_sda_low
);
   // clock stands high and data is released outside frames
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // data moves mid-low so it never races an scl edge through the synchroniser
   task automatic bit_cycle(input logic b, output logic s);
      o_sda_low = ~b;
      wait_clk(4);
      o_scl = 1'b1;
      wait_clk(4);
      s = i_sda;
      wait_clk(4);
      o_scl = 1'b0;
      wait_clk(4);
   endtask

   task automatic start_cond();
      o_sda_low = 1'b0;
      wait_clk(6);
      o_scl = 1'b1;
      wait_clk(6);
      o_sda_low = 1'b1;
      wait_clk(6);
      o_scl = 1'b0;
      wait_clk(4);
   endtask

   task automatic stop_cond();
      o_sda_low = 1'b1;
      wait_clk(6);
      o_scl = 1'b1;
      wait_clk(6);
      o_sda_low = 1'b0;
      wait_clk(6);
   endtask

   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = ~s;
   endtask

   // ack wanted bytes, nack the last
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++) begin
         bit_cycle(1'b1, s);
         d = {d[6:0], s};
      end
      bit_cycle(last, s);
   endtask
endmodule
